// ===== rtl/non_ip_key_builder.sv
`timescale 1ns/1ps
`default_nettype none
module non_ip_key_builder #(
   parameter int PORTS = 8,
   parameter int PORT_W = 3,
   parameter int WORDS = 9,
   parameter int WORD_W = 16
) (
   // clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // request from parser
   input wire logic req_valid,
   output logic req_ready,
   input wire logic [PORT_W-1:0] port_num,
   input wire logic outer_present,
   input wire logic [15:0] outer_tag,
   input wire logic [15:0] outer_default,
   input wire logic inner_present,
   input wire logic [15:0] inner_tag,
   input wire logic [15:0] inner_default,
   input wire logic [1:0] link_layer_format,
   input wire logic [15:0] ether_type,
   input wire logic [7:0] dsap,
   input wire logic [7:0] ssap,
   input wire logic ppp_seen,
   input wire logic [PORTS-1:0] session_parse_enable,
   input wire logic [WORDS*WORD_W-1:0] user_field_word,
   input wire logic [WORDS-1:0] user_word_valid,
   // key to rule lookup
   output logic key_valid,
   output logic [non_ip_key_pkg::KEY_W-1:0] key_data,
   output logic [1:0] slice_number
);

   ////////////////////////////////////////////////////////////////////////
   // decoding

   function automatic logic [PORTS-1:0] port_sel(input logic [PORT_W-1:0] p);
      port_sel = {{(PORTS-1){1'b0}}, 1'b1} << p;
   endfunction

   function automatic logic [1:0] state_slice(input non_ip_key_pkg::walk_state_t s);
      case (s)
         non_ip_key_pkg::ST_SLICE1: state_slice = 2'h1;
         non_ip_key_pkg::ST_SLICE2: state_slice = 2'h2;
         default: state_slice = 2'h0;
      endcase
   endfunction

   non_ip_key_pkg::walk_state_t state_q, state_d;
   logic [non_ip_key_pkg::KEY_W-1:4] body_q;
   logic [1:0] slice_q;
   wire logic [non_ip_key_pkg::KEY_W-1:4] body_d;
   wire logic fire;
   wire logic [1:0] otag_state;
   wire logic [1:0] itag_state;
   wire logic [15:0] otag_key;
   wire logic [15:0] itag_key;
   wire logic [15:0] type_field;
   wire logic [PORTS-1:0] port_map;
   wire logic ppp_flag;

   ////////////////////////////////////////////////////////////////////////
   // field builders

   vlan_tag_stage u_outer (
      .present(outer_present),
      .pkt_tag(outer_tag),
      .default_tag(outer_default),
      .tag_state(otag_state),
      .key_tag(otag_key)
   );

   vlan_tag_stage u_inner (
      .present(inner_present),
      .pkt_tag(inner_tag),
      .default_tag(inner_default),
      .tag_state(itag_state),
      .key_tag(itag_key)
   );

   type_field_select u_type (
      .link_layer_format(link_layer_format),
      .ether_type(ether_type),
      .dsap(dsap),
      .ssap(ssap),
      .type_or_sap_field(type_field)
   );

   // the lookup masks the port field; the key only marks the arrival port
   assign port_map = port_sel(port_num);
   assign ppp_flag = ppp_seen && |(port_map & session_parse_enable);

   ////////////////////////////////////////////////////////////////////////
   // key body assembly

   assign body_d[non_ip_key_pkg::PORT_HI:non_ip_key_pkg::PORT_LO] = port_map;
   assign body_d[non_ip_key_pkg::OST_HI:non_ip_key_pkg::OST_LO] = otag_state;
   assign body_d[non_ip_key_pkg::IST_HI:non_ip_key_pkg::IST_LO] = itag_state;
   assign body_d[non_ip_key_pkg::LINK_HI:non_ip_key_pkg::LINK_LO] = link_layer_format;
   assign body_d[non_ip_key_pkg::NET_HI:non_ip_key_pkg::NET_LO] = non_ip_key_pkg::NET_NON_IP;
   assign body_d[non_ip_key_pkg::TYPE_HI:non_ip_key_pkg::TYPE_LO] = type_field;
   assign body_d[non_ip_key_pkg::RSVA_HI:non_ip_key_pkg::RSVA_LO] = 5'h00;
   assign body_d[non_ip_key_pkg::PPP_BIT] = ppp_flag;
   assign body_d[non_ip_key_pkg::RSVB_BIT] = 1'b0;
   assign body_d[non_ip_key_pkg::UW8_VALID_BIT] = user_word_valid[WORDS-1];
   assign body_d[non_ip_key_pkg::UWV_HI:non_ip_key_pkg::UWV_LO] = user_word_valid[7:0];
   assign body_d[non_ip_key_pkg::OTAG_HI:non_ip_key_pkg::OTAG_LO] = otag_key;
   assign body_d[non_ip_key_pkg::ITAG_HI:non_ip_key_pkg::ITAG_LO] = itag_key;
   assign body_d[non_ip_key_pkg::RSVC_HI:non_ip_key_pkg::RSVC_LO] = 4'h0;
   // slice number and enable are added per step, not stored in the body

   // word w sits at the w-th slot above the low reserved nibble
   for (genvar w = 0; w < WORDS; w++) begin : g_word
      assign body_d[non_ip_key_pkg::UW_LO+w*WORD_W +: WORD_W] =
         user_field_word[w*WORD_W +: WORD_W];
   end

   ////////////////////////////////////////////////////////////////////////
   // slice walk: one key per cycle for slices 0, 1, 2

   // a new packet may be taken on the last slice cycle so keys run back to back
   assign req_ready = state_q == non_ip_key_pkg::ST_IDLE ||
      state_q == non_ip_key_pkg::ST_SLICE2;
   assign fire = req_valid && req_ready;

   always_comb begin
      case (state_q)
         non_ip_key_pkg::ST_IDLE: state_d = fire ? non_ip_key_pkg::ST_SLICE0 : non_ip_key_pkg::ST_IDLE;
         non_ip_key_pkg::ST_SLICE0: state_d = non_ip_key_pkg::ST_SLICE1;
         non_ip_key_pkg::ST_SLICE1: state_d = non_ip_key_pkg::ST_SLICE2;
         non_ip_key_pkg::ST_SLICE2: state_d = fire ? non_ip_key_pkg::ST_SLICE0 : non_ip_key_pkg::ST_IDLE;
         default: state_d = non_ip_key_pkg::ST_IDLE;
      endcase
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= non_ip_key_pkg::ST_IDLE;
         slice_q <= non_ip_key_pkg::SLICE_RESET;
      end else begin
         state_q <= state_d;
         slice_q <= state_slice(state_d);
      end
   end

   // body captured once per packet so all three slices see identical fields
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         body_q <= '0;
      end else if (fire) begin
         body_q <= body_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // key output

   assign key_valid = state_q != non_ip_key_pkg::ST_IDLE;
   assign key_data = {body_q, slice_q, non_ip_key_pkg::SLICE_ENABLE};
   assign slice_number = slice_q;

   ////////////////////////////////////////////////////////////////////////
   // checks

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   property p_port_map;
      fire |=> key_data[231:224] == (8'h01 << $past(port_num));
   endproperty
   a_port_map: assert property (p_port_map) else $error("port map wrong");

   property p_outer_state;
      fire |=> key_data[223:222] == (!$past(outer_present) ? 2'h0 :
         ($past(outer_tag[11:0]) == 12'h000 ? 2'h1 : 2'h3));
   endproperty
   a_outer_state: assert property (p_outer_state) else $error("outer tag state wrong");

   property p_inner_state;
      fire |=> key_data[221:220] == (!$past(inner_present) ? 2'h0 :
         ($past(inner_tag[11:0]) == 12'h000 ? 2'h1 : 2'h3));
   endproperty
   a_inner_state: assert property (p_inner_state) else $error("inner tag state wrong");

   property p_framing;
      fire |=> key_data[219:218] == $past(link_layer_format) && key_data[217:216] == 2'h3;
   endproperty
   a_framing: assert property (p_framing) else $error("framing fields wrong");

   property p_type;
      fire |=> key_data[215:200] == ($past(link_layer_format[1]) ?
         {$past(dsap), $past(ssap)} : $past(ether_type));
   endproperty
   a_type: assert property (p_type) else $error("type field wrong");

   property p_session;
      fire |=> key_data[194] == ($past(ppp_seen) && $past(session_parse_enable[port_num]));
   endproperty
   a_session: assert property (p_session) else $error("session flag wrong");

   property p_word_valid;
      fire |=> {key_data[192], key_data[191:184]} == $past(user_word_valid);
   endproperty
   a_word_valid: assert property (p_word_valid) else $error("word valid flags wrong");

   property p_tags;
      fire |=> key_data[183:168] == ($past(outer_present) ? $past(outer_tag) : $past(outer_default))
         && key_data[167:152] == ($past(inner_present) ? $past(inner_tag) : $past(inner_default));
   endproperty
   a_tags: assert property (p_tags) else $error("tag fields wrong");

   property p_words;
      fire |=> key_data[151:8] == $past(user_field_word);
   endproperty
   a_words: assert property (p_words) else $error("user words misplaced");

   property p_slice_walk;
      fire |=> key_valid && key_data[3:2] == 2'h0 ##1 key_valid && key_data[3:2] == 2'h1
         ##1 key_valid && key_data[3:2] == 2'h2;
   endproperty
   a_slice_walk: assert property (p_slice_walk) else $error("slice sequence wrong");

   property p_enable_pair;
      key_valid |-> key_data[1:0] == 2'h3 && key_data[3:2] != 2'h3;
   endproperty
   a_enable_pair: assert property (p_enable_pair) else $error("slice enable pair wrong");

   property p_reserved;
      key_valid |-> key_data[199:195] == 5'h00 && !key_data[193] && key_data[7:4] == 4'h0;
   endproperty
   a_reserved: assert property (p_reserved) else $error("reserved bits set");

   property p_body_stable;
      key_valid && slice_number != 2'h2 |=> key_valid && $stable(key_data[231:4]);
   endproperty
   a_body_stable: assert property (p_body_stable) else $error("key body changed mid walk");

   ////////////////////////////////////////////////////////////////////////
   // handshake and walk shape checks

   property p_refuse_mid_walk;
      key_valid && slice_number != 2'h2 |-> !req_ready;
   endproperty
   a_refuse_mid_walk: assert property (p_refuse_mid_walk) else $error("request accepted mid walk");

   property p_ready_last_slice;
      key_valid && slice_number == 2'h2 |-> req_ready;
   endproperty
   a_ready_last_slice: assert property (p_ready_last_slice) else $error("not ready on last slice");

   property p_ready_idle;
      !key_valid |-> req_ready;
   endproperty
   a_ready_idle: assert property (p_ready_idle) else $error("not ready while idle");

   property p_walk_ends;
      key_valid && slice_number == 2'h2 && !req_valid |=> !key_valid;
   endproperty
   a_walk_ends: assert property (p_walk_ends) else $error("walk ran past slice 2");

   property p_walk_chains;
      key_valid && slice_number == 2'h2 && req_valid |=> key_valid && slice_number == 2'h0;
   endproperty
   a_walk_chains: assert property (p_walk_chains) else $error("gap between chained packets");

   property p_no_key_unasked;
      !key_valid && !req_valid |=> !key_valid;
   endproperty
   a_no_key_unasked: assert property (p_no_key_unasked) else $error("key without request");

   property p_session_blocked;
      fire && !session_parse_enable[port_num] |=> !key_data[194];
   endproperty
   a_session_blocked: assert property (p_session_blocked) else $error("session flag on disabled port");

   property p_port_one_hot;
      key_valid |-> $onehot(key_data[231:224]);
   endproperty
   a_port_one_hot: assert property (p_port_one_hot) else $error("port field not one-hot");

   property p_tag_codes_legal;
      key_valid |-> key_data[223:222] != 2'h2 && key_data[221:220] != 2'h2;
   endproperty
   a_tag_codes_legal: assert property (p_tag_codes_legal) else $error("reserved tag state code");

   property p_net_format_each;
      key_valid |-> key_data[217:216] == 2'h3;
   endproperty
   a_net_format_each: assert property (p_net_format_each) else $error("network format not non-ip");

   property p_body_held;
      !fire |=> $stable(key_data[231:4]);
   endproperty
   a_body_held: assert property (p_body_held) else $error("key body moved without request");

   // keys shown for the packet in flight; a gap or a repeat slips against the slice field
   logic [1:0] run_q;

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         run_q <= 2'h0;
      end else if (fire) begin
         run_q <= 2'h0;
      end else if (key_valid) begin
         run_q <= run_q + 2'h1;
      end
   end

   property p_run_matches_slice;
      key_valid |-> slice_number == run_q;
   endproperty
   a_run_matches_slice: assert property (p_run_matches_slice) else $error("slice out of step");

endmodule // non_ip_key_builder
`default_nettype wire

// ===== rtl/non_ip_key_pkg.sv
// Behaviour
// - top byte carries ingress port select map
// - outer tag state: 00 none, 01 zero, 11
// - inner tag state: 00 none, 01 zero, 11
// - link format code; network format fixed 11
// - type field: EtherType or destination/source SAP
// - session flag set only for session packets
// - ninth user word valid at own bit
// - eight user word valid flags, index-ordered byte
// - outer tag from packet, else port default
// - inner tag from packet, else port default
// - nine user words, word eight highest
// - slice number field names searched slice
// - session flag needs port parse enable
// - two lowest bits always slice enable 11
package non_ip_key_pkg;

   localparam int KEY_W = 232;
   localparam int VID_W = 12;

   ////////////////////////////////////////////////////////////////////////
   // key field positions
   localparam int PORT_HI = 231;
   localparam int PORT_LO = 224;
   localparam int OST_HI = 223;
   localparam int OST_LO = 222;
   localparam int IST_HI = 221;
   localparam int IST_LO = 220;
   localparam int LINK_HI = 219;
   localparam int LINK_LO = 218;
   localparam int NET_HI = 217;
   localparam int NET_LO = 216;
   localparam int TYPE_HI = 215;
   localparam int TYPE_LO = 200;
   localparam int RSVA_HI = 199;
   localparam int RSVA_LO = 195;
   localparam int PPP_BIT = 194;
   localparam int RSVB_BIT = 193;
   localparam int UW8_VALID_BIT = 192;
   localparam int UWV_HI = 191;
   localparam int UWV_LO = 184;
   localparam int OTAG_HI = 183;
   localparam int OTAG_LO = 168;
   localparam int ITAG_HI = 167;
   localparam int ITAG_LO = 152;
   localparam int UW_LO = 8;
   localparam int RSVC_HI = 7;
   localparam int RSVC_LO = 4;
   localparam int SLICE_HI = 3;
   localparam int SLICE_LO = 2;

   ////////////////////////////////////////////////////////////////////////
   // codes and reset values
   localparam logic [1:0] TAG_ABSENT = 2'h0;
   localparam logic [1:0] TAG_VID_ZERO = 2'h1;
   localparam logic [1:0] TAG_VID_NONZERO = 2'h3;
   localparam logic [1:0] TAG_RESERVED = 2'h2;
   localparam logic [1:0] LINK_DIX = 2'h0;
   localparam logic [1:0] LINK_SNAP_PUB = 2'h1;
   localparam logic [1:0] LINK_LLC = 2'h2;
   localparam logic [1:0] LINK_SNAP_PRIV = 2'h3;
   localparam logic [1:0] NET_NON_IP = 2'h3;
   localparam logic [1:0] SLICE_ENABLE = 2'h3;
   localparam logic [1:0] SLICE_FIRST = 2'h0;
   localparam logic [1:0] SLICE_LAST = 2'h2;
   localparam logic [1:0] SLICE_RESET = 2'h0;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_SLICE0 = 2'b01,
      ST_SLICE1 = 2'b10,
      ST_SLICE2 = 2'b11
   } walk_state_t;

endpackage

// ===== rtl/type_field_select.sv
`timescale 1ns/1ps
`default_nettype none
module type_field_select (
   // framing
   input wire logic [1:0] link_layer_format,
   input wire logic [15:0] ether_type,
   input wire logic [7:0] dsap,
   input wire logic [7:0] ssap,
   // key field
   output logic [15:0] type_or_sap_field
);
   wire logic use_sap;

   assign use_sap = link_layer_format == non_ip_key_pkg::LINK_LLC ||
      link_layer_format == non_ip_key_pkg::LINK_SNAP_PRIV;
   assign type_or_sap_field = use_sap ? {dsap, ssap} : ether_type;
endmodule // type_field_select
`default_nettype wire

// ===== rtl/vlan_tag_stage.sv
`timescale 1ns/1ps
`default_nettype none
module vlan_tag_stage (
   // packet tag
   input wire logic present,
   input wire logic [15:0] pkt_tag,
   input wire logic [15:0] default_tag,
   // key fields
   output logic [1:0] tag_state,
   output logic [15:0] key_tag
);
   wire logic vid_zero;

   assign vid_zero = pkt_tag[non_ip_key_pkg::VID_W-1:0] == 12'h000;
   // reserved code 10 can never come out of this select
   assign tag_state = !present ? non_ip_key_pkg::TAG_ABSENT :
      (vid_zero ? non_ip_key_pkg::TAG_VID_ZERO : non_ip_key_pkg::TAG_VID_NONZERO);
   assign key_tag = present ? pkt_tag : default_tag;
endmodule // vlan_tag_stage
`default_nettype wire

// ===== testbench/key_sink.sv
`timescale 1ns/1ps
`default_nettype none
// rule lookup stand-in: it never stalls, because the builder has no back-pressure
module key_sink (
   // key from builder
   input wire logic mclk,
   input wire logic key_valid,
   input wire logic [231:0] key_data,
   input wire logic [1:0] slice_number
);
   logic [231:0] keys[$];
   logic [1:0] slices[$];
   ////////////////////////////////////////////////////////////////////////
   always @(posedge mclk) begin
      if (key_valid === 1'b1) begin
         keys.push_back(key_data);
         slices.push_back(slice_number);
      end
   end
endmodule // key_sink
`default_nettype wire

// ===== testbench/non_ip_classifier_key_builder_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin fails++; \
   $display("unexpected %s exp %h got %h", nm, e, g); end end
module non_ip_classifier_key_builder_tb_top;
   logic mclk = 1'b0;
   logic rst_n = 1'b0;
   logic req_valid = 1'b0;
   logic req_ready;
   logic [2:0] port_num = 3'h0;
   logic outer_present = 1'b0;
   logic [15:0] outer_tag = 16'h0;
   logic [15:0] outer_default = 16'h0;
   logic inner_present = 1'b0;
   logic [15:0] inner_tag = 16'h0;
   logic [15:0] inner_default = 16'h0;
   logic [1:0] link_layer_format = 2'h0;
   logic [15:0] ether_type = 16'h0;
   logic [7:0] dsap = 8'h0;
   logic [7:0] ssap = 8'h0;
   logic ppp_seen = 1'b0;
   logic [7:0] session_parse_enable = 8'h0;
   logic [143:0] user_field_word = 144'h0;
   logic [8:0] user_word_valid = 9'h0;
   logic key_valid;
   logic [231:0] key_data;
   logic [1:0] slice_number;
   logic [231:0] expq[$];
   int fails = 0;
   int n_tests = 0;
   ////////////////////////////////////////////////////////////////////////
   non_ip_key_builder dut_u (.mclk(mclk), .rst_n(rst_n), .req_valid(req_valid), .req_ready(req_ready),
      .port_num(port_num), .outer_present(outer_present), .outer_tag(outer_tag),
      .outer_default(outer_default), .inner_present(inner_present), .inner_tag(inner_tag),
      .inner_default(inner_default), .link_layer_format(link_layer_format), .ether_type(ether_type),
      .dsap(dsap), .ssap(ssap), .ppp_seen(ppp_seen), .session_parse_enable(session_parse_enable),
      .user_field_word(user_field_word), .user_word_valid(user_word_valid), .key_valid(key_valid),
      .key_data(key_data), .slice_number(slice_number));
   key_sink sink_u (.mclk(mclk), .key_valid(key_valid), .key_data(key_data), .slice_number(slice_number));
   initial begin
      forever #2.5 mclk = ~mclk;
   end
   ////////////////////////////////////////////////////////////////////////
   // expected key worked out field by field from the current inputs
   function automatic logic [231:0] exp_key(input logic [1:0] sl);
      logic [231:0] k;
      k = '0;
      k[231:224] = 8'h01 << port_num;
      k[223:222] = !outer_present ? 2'h0 : (outer_tag[11:0] == 12'h0 ? 2'h1 : 2'h3);
      k[221:220] = !inner_present ? 2'h0 : (inner_tag[11:0] == 12'h0 ? 2'h1 : 2'h3);
      k[219:218] = link_layer_format;
      k[217:216] = 2'h3;
      k[215:200] = link_layer_format[1] ? {dsap, ssap} : ether_type;
      k[194] = ppp_seen & session_parse_enable[port_num];
      k[192:184] = user_word_valid;
      k[183:168] = outer_present ? outer_tag : outer_default;
      k[167:152] = inner_present ? inner_tag : inner_default;
      k[151:8] = user_field_word;
      k[3:2] = sl;
      k[1:0] = 2'h3;
      return k;
   endfunction
   // holds req_valid until taken; back-to-back calls keep it high between packets
   task automatic send();
      int n;
      req_valid = 1'b1;
      for (int s = 0; s < 3; s++) expq.push_back(exp_key(s[1:0]));
      n = 0;
      while (req_ready !== 1'b1 && n < 10) begin
         @(posedge mclk);
         #1;
         n++;
      end
      `CHK("req_ready_wait", 1'b1, req_ready)
      @(posedge mclk);
      #1;
   endtask
   task automatic drain_check();
      req_valid = 1'b0;
      repeat (4) @(posedge mclk);
      #1;
      `CHK("key_valid", 1'b0, key_valid)
      `CHK("key_count", expq.size(), sink_u.keys.size())
      for (int i = 0; i < expq.size(); i++) begin
         `CHK("key", expq[i], sink_u.keys[i])
         `CHK("slice_number", expq[i][3:2], sink_u.slices[i])
      end
      expq.delete();
      sink_u.keys.delete();
      sink_u.slices.delete();
   endtask
   ////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      `CHK("reset_key", {230'h0, 2'h3}, key_data)
      `CHK("reset_valid", 1'b0, key_valid)
      `CHK("reset_ready", 1'b1, req_ready)
   endtask
   // every framing code, tags absent so port defaults must show
   task automatic t_link();
      for (int f = 0; f < 4; f++) begin
         @(posedge mclk);
         #1;
         link_layer_format = f[1:0];
         port_num = 3'(f * 2 + 1);
         ether_type = 16'h88B5 + 16'(f);
         dsap = 8'hA5;
         ssap = 8'h3C;
         outer_default = 16'hE00F;
         inner_default = 16'h1FFE;
         ppp_seen = 1'b1;
         session_parse_enable = 8'hFF;
         user_word_valid = 9'h100;
         send();
         drain_check();
      end
   endtask
   // zero and nonzero tag IDs, session flag blocked by port enable
   task automatic t_tags();
      @(posedge mclk);
      #1;
      port_num = 3'h6;
      outer_present = 1'b1;
      outer_tag = 16'hA000;
      inner_present = 1'b1;
      inner_tag = 16'h0001;
      ppp_seen = 1'b1;
      session_parse_enable = 8'hBF;
      user_word_valid = 9'h0AA;
      for (int w = 0; w < 9; w++) user_field_word[w*16 +: 16] = 16'h1000 * 16'(w) + 16'h00F1;
      send();
      drain_check();
   endtask
   // refused while slices 0 and 1 run, then keys follow without a gap
   task automatic t_b2b();
      @(posedge mclk);
      #1;
      port_num = 3'h7;
      outer_present = 1'b0;
      link_layer_format = 2'h2;
      send();
      `CHK("ready_slice0", 1'b0, req_ready)
      port_num = 3'h0;
      inner_tag = 16'hF000;
      session_parse_enable = 8'h01;
      send();
      `CHK("gapless_valid", 1'b1, key_valid)
      `CHK("gapless_slice", 2'h0, slice_number)
      @(posedge mclk);
      #1;
      `CHK("ready_slice1", 1'b0, req_ready)
      port_num = 3'h4;
      inner_present = 1'b0;
      outer_present = 1'b1;
      outer_tag = 16'h6123;
      ppp_seen = 1'b0;
      session_parse_enable = 8'hFF;
      send();
      drain_check();
   endtask
   // reset dropped in mid walk: keys stop at once, the next packet runs clean
   task automatic t_mid_reset();
      @(posedge mclk);
      #1;
      send();
      rst_n = 1'b0;
      req_valid = 1'b0;
      #1;
      `CHK("mid_reset_valid", 1'b0, key_valid)
      `CHK("mid_reset_key", {230'h0, 2'h3}, key_data)
      `CHK("mid_reset_ready", 1'b1, req_ready)
      @(posedge mclk);
      #1;
      rst_n = 1'b1;
      expq.delete();
      sink_u.keys.delete();
      sink_u.slices.delete();
      send();
      drain_check();
   endtask
   ////////////////////////////////////////////////////////////////////////
   task automatic report_and_stop();
      if (fails == 0 && n_tests > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   initial begin
      #20000;
      fails++;
      report_and_stop();
   end
   initial begin
      repeat (8) @(posedge mclk);
      #1;
      t_reset();
      rst_n = 1'b1;
      t_link();
      t_tags();
      t_b2b();
      t_mid_reset();
      report_and_stop();
   end
endmodule // non_ip_classifier_key_builder_tb_top
`default_nettype wire
